// ---- design/mrs_result_engine.sv ----
`include "mrs_regs.svh"
`default_nettype none
// How it works
// - Temperature is 16-bit two's complement, 7FF8 top, 8000 bottom.
// - Temperature code carries 1/256 degree per count.
// - Programmed temperature offset is added to every temperature conversion.
// - Supply and three inputs are converted in repeating round-robin order.
// - Voltage results stored left justified, unsigned 16-bit at 62h..69h.
// - Full scale gives FFF8h, null input gives all zeros.
// - Each analog input has its own 3-bit shift count, zero to seven.
// - Shift applied every input conversion after gain and offset, before storing.
// - Supply and each input use their own gain and offset.
// - Factory weight is span over 65528 counts.
// - Temperature at 60h/61h, refreshed per frame, held during memory access.
// - Gain and offset values are each two bytes wide.
// - Temperature uses offset only, no gain.
module mrs_result_engine (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic [12:0] sampleCode,
    input wire logic memBusy,
    input wire logic [15:0] tempOffset,
    input wire logic [15:0] supplyGain,
    input wire logic [15:0] supplyOffset,
    input wire logic [15:0] inputAGain,
    input wire logic [15:0] inputAOffset,
    input wire logic [2:0] inputAShift,
    input wire logic [15:0] inputBGain,
    input wire logic [15:0] inputBOffset,
    input wire logic [2:0] inputBShift,
    input wire logic [15:0] inputCGain,
    input wire logic [15:0] inputCOffset,
    input wire logic [2:0] inputCShift,
    output logic [2:0] channelSelect,
    output logic convertStart,
    output logic [15:0] tempResult,
    output logic [15:0] supplyResult,
    output logic [15:0] inputAResult,
    output logic [15:0] inputBResult,
    output logic [15:0] inputCResult,
    output mrs_pkg::mrs_result_t lastResult,
    output logic resultStrobe
);
    mrs_pkg::mrs_chan_t chanReg;
    mrs_pkg::mrs_chan_t chanNext;
    logic [15:0] slotCountReg;
    logic [12:0] rawReg;
    logic scaleStart;
    logic scaleDone;
    logic [15:0] scaled;
    logic pendingReg;
    logic [15:0] pendingData;
    mrs_pkg::mrs_chan_t pendingChan;
    mrs_pkg::mrs_cal_t calSel;

    // Byte address of a channel's result pair
    function automatic logic [7:0] chanAddr(input mrs_pkg::mrs_chan_t ch);
        case (ch)
            mrs_pkg::CH_TEMP: chanAddr = `MRS_ADDR_TEMP;
            mrs_pkg::CH_SUPPLY: chanAddr = `MRS_ADDR_SUPPLY;
            mrs_pkg::CH_IN_A: chanAddr = `MRS_ADDR_IN_A;
            mrs_pkg::CH_IN_B: chanAddr = `MRS_ADDR_IN_B;
            mrs_pkg::CH_IN_C: chanAddr = `MRS_ADDR_IN_C;
            default: chanAddr = `MRS_ADDR_TEMP;
        endcase
    endfunction

    // -------------------------------------------------
    // Round-robin sequencer
    // -------------------------------------------------
    // Next channel in the fixed order
    always_comb begin
        case (chanReg)
            mrs_pkg::CH_TEMP: chanNext = mrs_pkg::CH_SUPPLY;
            mrs_pkg::CH_SUPPLY: chanNext = mrs_pkg::CH_IN_A;
            mrs_pkg::CH_IN_A: chanNext = mrs_pkg::CH_IN_B;
            mrs_pkg::CH_IN_B: chanNext = mrs_pkg::CH_IN_C;
            mrs_pkg::CH_IN_C: chanNext = mrs_pkg::CH_TEMP;
            default: chanNext = mrs_pkg::CH_TEMP;
        endcase
    end

    // Fixed slot length, five slots make one frame period
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            slotCountReg <= 16'h0000;
            chanReg <= mrs_pkg::CH_TEMP;
            convertStart <= 1'b0;
            channelSelect <= 3'h0;
        end else begin
            convertStart <= 1'b0;
            if (slotCountReg == `MRS_SLOT_LAST) begin
                slotCountReg <= 16'h0000;
                chanReg <= chanNext;
                channelSelect <= chanNext;
                convertStart <= 1'b1;
            end else begin
                slotCountReg <= slotCountReg + 16'h0001;
            end
        end
    end

    // -------------------------------------------------
    // Calibration select
    // -------------------------------------------------
    // Each channel owns its own set; temperature has offset only
    // Two-byte gain and offset words, full 16-bit span each
    always_comb begin
        calSel.gain = 16'h0000;
        calSel.offset = tempOffset;
        calSel.shift = 3'h0;
        case (chanReg)
            mrs_pkg::CH_TEMP: begin
                calSel.offset = tempOffset;
            end
            mrs_pkg::CH_SUPPLY: begin
                calSel.gain = supplyGain;
                calSel.offset = supplyOffset;
            end
            mrs_pkg::CH_IN_A: begin
                calSel.gain = inputAGain;
                calSel.offset = inputAOffset;
                calSel.shift = inputAShift;
            end
            mrs_pkg::CH_IN_B: begin
                calSel.gain = inputBGain;
                calSel.offset = inputBOffset;
                calSel.shift = inputBShift;
            end
            mrs_pkg::CH_IN_C: begin
                calSel.gain = inputCGain;
                calSel.offset = inputCOffset;
                calSel.shift = inputCShift;
            end
            default: begin
                calSel.offset = tempOffset;
            end
        endcase
    end

    // -------------------------------------------------
    // Sample capture
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rawReg <= 13'h0000;
            scaleStart <= 1'b0;
        end else begin
            scaleStart <= sampleValid;
            if (sampleValid) begin
                rawReg <= sampleCode;
            end
        end
    end

    mrs_scaler scaler (
        .clk(clk),
        .rst_b(rst_b),
        .start(scaleStart),
        .isTemp(chanReg == mrs_pkg::CH_TEMP),
        .raw(rawReg),
        .cal(calSel),
        .done(scaleDone),
        .result(scaled)
    );

    // -------------------------------------------------
    // Result hold-off
    // -------------------------------------------------
    // A finished result waits while memory is busy; a newer one replaces it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pendingReg <= 1'b0;
            pendingData <= `MRS_ZERO16;
            pendingChan <= mrs_pkg::CH_TEMP;
        end else if (scaleDone && memBusy) begin
            pendingReg <= 1'b1;
            pendingData <= scaled;
            pendingChan <= chanReg;
        end else if (!memBusy) begin
            pendingReg <= 1'b0;
        end
    end

    // -------------------------------------------------
    // Measurement registers
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tempResult <= `MRS_ZERO16;
            supplyResult <= `MRS_ZERO16;
            inputAResult <= `MRS_ZERO16;
            inputBResult <= `MRS_ZERO16;
            inputCResult <= `MRS_ZERO16;
            lastResult <= '0;
            resultStrobe <= 1'b0;
        end else begin
            resultStrobe <= 1'b0;
            if (!memBusy && (scaleDone || pendingReg)) begin
                resultStrobe <= 1'b1;
                lastResult.data <= scaleDone ? scaled : pendingData;
                lastResult.addr <= chanAddr(scaleDone ? chanReg : pendingChan);
                case (scaleDone ? chanReg : pendingChan)
                    mrs_pkg::CH_TEMP: tempResult <= scaleDone ? scaled : pendingData;
                    mrs_pkg::CH_SUPPLY: supplyResult <= scaleDone ? scaled : pendingData;
                    mrs_pkg::CH_IN_A: inputAResult <= scaleDone ? scaled : pendingData;
                    mrs_pkg::CH_IN_B: inputBResult <= scaleDone ? scaled : pendingData;
                    mrs_pkg::CH_IN_C: inputCResult <= scaleDone ? scaled : pendingData;
                    default: tempResult <= tempResult;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- pkg/mrs_regs.svh ----
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// Result register byte addresses
`define MRS_ADDR_TEMP 8'h60
`define MRS_ADDR_SUPPLY 8'h62
`define MRS_ADDR_IN_A 8'h64
`define MRS_ADDR_IN_B 8'h66
`define MRS_ADDR_IN_C 8'h68
`define MRS_ADDR_LAST 8'h69
// Codes
`define MRS_FULL_SCALE 16'hfff8
`define MRS_TEMP_POS_FS 16'h7ff8
`define MRS_TEMP_NEG_FS 16'h8000
`define MRS_RESULT_MASK 16'hfff8
`define MRS_ZERO16 16'h0000
// Converter width and left-justify shift
`define MRS_ADC_BITS 13
`define MRS_JUSTIFY 3
// Gain: unity is 16'h8000, product shifted by 15
`define MRS_GAIN_SHIFT 15
// Offset weight: register value times 4 is added
`define MRS_OFFSET_SHIFT 2
// Frame period: 5 slots, each slot a fixed number of clocks
`define MRS_SLOT_CYCLES 16'd2000
`define MRS_SLOT_LAST 16'd1999

`endif

// ---- pkg/mrs_pkg.sv ----
`default_nettype none
package mrs_pkg;
    typedef enum logic [2:0] {
        CH_TEMP,
        CH_SUPPLY,
        CH_IN_A,
        CH_IN_B,
        CH_IN_C
    } mrs_chan_t;

    // Per-channel calibration set
    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] offset;
        logic [2:0] shift;
    } mrs_cal_t;

    // One finished conversion
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } mrs_result_t;
endpackage
`default_nettype wire

// ---- design/mrs_scaler.sv ----
`include "mrs_regs.svh"
`default_nettype none
// Gain, offset, clamp and right shift for one raw sample (one-cycle result)
module mrs_scaler (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic isTemp,
    input wire logic [12:0] raw,
    input wire mrs_pkg::mrs_cal_t cal,
    output logic done,
    output logic [15:0] result
);
    logic [15:0] justified;
    logic [32:0] product;
    logic signed [19:0] sum;
    logic [15:0] clamped;
    logic [15:0] shifted;

    // -------------------------------------------------
    // Datapath
    // -------------------------------------------------
    always_comb begin
        justified = {raw, 3'h0};
        // Temperature has no gain stage
        product = isTemp ? {2'b00, justified, `MRS_GAIN_SHIFT'h0}
                         : {1'b0, justified} * {17'h0, cal.gain};
        sum = $signed({1'b0, product[33-2:`MRS_GAIN_SHIFT]})
            + ($signed({{2{cal.offset[15]}}, cal.offset, 2'h0}));
        if (isTemp) begin
            // Two's complement wraps: low 16 bits kept, no clamp to the signed span
            clamped = sum[15:0] & `MRS_RESULT_MASK;
        end else if (sum < 0) begin
            clamped = `MRS_ZERO16;
        end else if (sum > $signed({4'h0, `MRS_FULL_SCALE})) begin
            clamped = `MRS_FULL_SCALE;
        end else begin
            clamped = sum[15:0] & `MRS_RESULT_MASK;
        end
        shifted = isTemp ? clamped : (clamped >> cal.shift);
    end

    // -------------------------------------------------
    // Output stage
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            result <= `MRS_ZERO16;
        end else begin
            done <= start;
            if (start) begin
                result <= shifted;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/mrs_result_monitor.sv ----
`include "mrs_regs.svh"
`default_nettype none
module mrs_result_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic memBusy,
    input wire logic [2:0] channelSelect,
    input wire logic convertStart,
    input wire logic [15:0] tempResult,
    input wire logic [15:0] supplyResult,
    input wire mrs_pkg::mrs_result_t lastResult,
    input wire logic resultStrobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ----
    // Slot timer
    // ----
    logic [15:0] slotCnt;
    logic slotSeen;
    // Cycles since the last conversion start
    always_ff @(posedge clk) begin
        if (!rst_b || convertStart) slotCnt <= 16'h0;
        else slotCnt <= slotCnt + 16'h1;
    end
    // Armed after the first start only: the gap from reset is not a whole slot
    always_ff @(posedge clk) begin
        if (!rst_b) slotSeen <= 1'b0;
        else if (convertStart) slotSeen <= 1'b1;
    end
    // ----
    // Checks
    // ----
    slot_len_a: assert property (convertStart && slotSeen |-> slotCnt == `MRS_SLOT_LAST)
        else $error("slot length wrong");
    rr_order_a: assert property ($changed(channelSelect) |-> channelSelect ==
        (($past(channelSelect) == 3'h4) ? 3'h0 : $past(channelSelect) + 3'h1))
        else $error("channel order wrong");
    store_timing_a: assert property (sampleValid && !memBusy ##1 !memBusy ##1 !memBusy
        |=> resultStrobe && lastResult.addr == 8'h60 + {4'h0, $past(channelSelect, 3), 1'b0})
        else $error("store late or wrong address");
    busy_hold_a: assert property ($past(memBusy) |-> !resultStrobe)
        else $error("store during memory access");
    temp_copy_a: assert property (resultStrobe && lastResult.addr == 8'h60
        |-> lastResult.data == tempResult && tempResult[2:0] == 3'h0)
        else $error("temperature store wrong");
    supply_copy_a: assert property (resultStrobe && lastResult.addr == 8'h62
        |-> lastResult.data == supplyResult)
        else $error("supply store wrong");
    supply_range_a: assert property (supplyResult <= `MRS_FULL_SCALE)
        else $error("supply above full scale");
    strobe_pulse_a: assert property (resultStrobe |=> !resultStrobe)
        else $error("strobe too long");
    start_pulse_a: assert property (convertStart |=> !convertStart)
        else $error("start too long");
endmodule
`default_nettype wire

// ---- bench/tb_mrs_result_engine.sv ----
`default_nettype none
module tb_mrs_result_engine;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_b;
    logic valid;
    logic busy;
    logic [12:0] code;
    logic [15:0] gain [0:4];
    logic [15:0] offs [0:4];
    logic [2:0] shift [0:4];
    logic [2:0] chSel;
    logic cStart;
    logic strobe;
    logic [15:0] res [0:4];
    mrs_pkg::mrs_result_t lastRes;
    int badCount = 0;
    int testsRun = 0;

    mrs_result_engine uut (.clk(clk), .rst_b(rst_b), .sampleValid(valid),
        .sampleCode(code), .memBusy(busy), .tempOffset(offs[0]),
        .supplyGain(gain[1]), .supplyOffset(offs[1]),
        .inputAGain(gain[2]), .inputAOffset(offs[2]), .inputAShift(shift[2]),
        .inputBGain(gain[3]), .inputBOffset(offs[3]), .inputBShift(shift[3]),
        .inputCGain(gain[4]), .inputCOffset(offs[4]), .inputCShift(shift[4]),
        .channelSelect(chSel), .convertStart(cStart), .tempResult(res[0]),
        .supplyResult(res[1]), .inputAResult(res[2]), .inputBResult(res[3]),
        .inputCResult(res[4]), .lastResult(lastRes), .resultStrobe(strobe));

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One sample in the next slot of channel ch; memory stays busy for hold cycles
    task automatic conv(input logic [2:0] ch, input logic [12:0] raw, input logic [15:0] g,
        input logic [15:0] o, input logic [2:0] s, input int hold, input logic [15:0] exp);
        int n;
        n = 0;
        while (cStart !== 1'b1 && n < 2100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check16("channel", {13'h0, ch}, {13'h0, chSel});
        @(posedge clk) valid <= 1'b1;
        code <= raw;
        gain[ch] <= g;
        offs[ch] <= o;
        shift[ch] <= s;
        busy <= (hold != 0);
        @(posedge clk) valid <= 1'b0;
        for (n = 0; n < hold; n++) begin
            @(posedge clk);
            #1;
            check16("held strobe", 16'h0, {15'h0, strobe});
        end
        busy <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (strobe !== 1'b1 && n < 40);
        check16("stored", exp, lastRes.data);
        check16("address", {8'h0, 8'h60 + {4'h0, ch, 1'b0}}, {8'h0, lastRes.addr});
        check16("register", exp, res[ch]);
    endtask

    // Full scale, null, clamp and the first shifts
    task automatic scaleFull();
        conv(3'h1, 13'h1000, 16'h8000, 16'h0, 3'h0, 0, 16'h8000);
        conv(3'h2, 13'h1fff, 16'h8000, 16'h0, 3'h0, 0, 16'hfff8);
        conv(3'h3, 13'h1fff, 16'hffff, 16'h0, 3'h1, 0, 16'h7ffc);
        conv(3'h4, 13'h0000, 16'h8000, 16'h0, 3'h2, 0, 16'h0000);
        conv(3'h0, 13'h0fff, 16'h0, 16'h0, 3'h0, 0, 16'h7ff8);
    endtask

    // Offsets land before the shift; temperature offset is added
    task automatic offsetShift();
        conv(3'h1, 13'h1000, 16'h4000, 16'h0010, 3'h0, 0, 16'h4040);
        conv(3'h2, 13'h1000, 16'h8000, 16'hffe0, 3'h3, 0, 16'h0ff0);
        conv(3'h3, 13'h0010, 16'h8000, 16'hff00, 3'h4, 0, 16'h0000);
        conv(3'h4, 13'h1fff, 16'h8000, 16'h0, 3'h5, 0, 16'h07ff);
        conv(3'h0, 13'h1000, 16'h0, 16'h0040, 3'h0, 0, 16'h8100);
    endtask

    // Stores held off by memory access; deepest shifts
    task automatic busyHold();
        conv(3'h1, 13'h0800, 16'h8000, 16'h0, 3'h0, 12, 16'h4000);
        conv(3'h2, 13'h1fff, 16'h8000, 16'h0, 3'h6, 0, 16'h03ff);
        conv(3'h3, 13'h1fff, 16'h8000, 16'h0, 3'h7, 0, 16'h01ff);
        conv(3'h4, 13'h1000, 16'h8000, 16'h0, 3'h0, 0, 16'h8000);
        conv(3'h0, 13'h1000, 16'h0, 16'h0, 3'h0, 12, 16'h8000);
    endtask

    // Host-side calibration steps: trial gain, null reading, offset fix
    task automatic hostCal();
        conv(3'h1, 13'h1ccc, 16'hffff, 16'h0, 3'h0, 0, 16'hfff8);
        conv(3'h2, 13'h0100, 16'h8000, 16'h0, 3'h0, 0, 16'h0800);
        conv(3'h3, 13'h0100, 16'h8000, 16'hfe00, 3'h0, 0, 16'h0000);
        conv(3'h4, 13'h1ccc, 16'h8000, 16'h0, 3'h0, 0, 16'he660);
        conv(3'h0, 13'h0c80, 16'h0, 16'h0, 3'h0, 0, 16'h6400);
    endtask

    task automatic summarize();
        if (badCount == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----
    // Clock, watchdog, main sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Four frames of five 2000-cycle slots need about 40000 cycles
    initial begin
        #(60000 * 100);
        badCount++;
        summarize();
    end
    initial begin
        rst_b = 1'b0;
        valid = 1'b0;
        busy = 1'b0;
        code = 13'h0;
        for (int i = 0; i < 5; i++) begin
            gain[i] = 16'h8000;
            offs[i] = 16'h0;
            shift[i] = 3'h0;
        end
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        scaleFull();
        offsetShift();
        busyHold();
        hostCal();
        summarize();
    end
endmodule

bind mrs_result_engine mrs_result_monitor mon (.clk(clk), .rst_b(rst_b),
    .sampleValid(sampleValid), .memBusy(memBusy), .channelSelect(channelSelect),
    .convertStart(convertStart), .tempResult(tempResult), .supplyResult(supplyResult),
    .lastResult(lastResult), .resultStrobe(resultStrobe));
`default_nettype wire
